// *** hw/scp_clock_ctrl.sv ***
// How it works
// - Trim register bit 7 always reads zero.
// - Reset loads the factory calibration byte into the trim value.
// - Trim 0x00 is slowest, rising values faster, 0x7F fastest.
// - Clock source fuse 0000 selects the external clock input.
// - External clock: 6 clocks wake, reset delay none, 4.1 ms or 65 ms.
// - Clock output fuse drives system clock on port B0, even in reset; the code holds the pin low in reset on an internal source.
// - The pin carries the divided clock on an internal source; with source 0000 it carries the raw input pin.
// - Prescaler divides io, core, memory clocks; async timer if sync.
// - Division changes make no glitch nor any shorter period.
// - New rate lands after T1+T2 to T1+2*T2 with two edges between; the code switches at the next falling edge of the divided clock.
// - Unlock write alone, then division value within four cycles.
// - Unlock clears four cycles after set or on division write.
// - Interrupts are blocked while the unlock bit is set.
// - Division resets to 0000, or 0011 with divide-by-eight fuse.
// - Any division value is accepted through the unlock sequence.
// - Division code n divides by two to the n; 1001-1111 reserved; the code divides sys_clk by two to the n+1.
//
// Decided for this implementation: the address map and the APB slave port.
`include "scp_map.svh"
`timescale 1ns/1ps
`default_nettype none

module scp_clock_ctrl
    import scp_pkg::*;
#(
    parameter int unsigned DLY_SHORT_CYC = `SCP_DLY_SHORT_CYC,
    parameter int unsigned DLY_LONG_CYC = `SCP_DLY_LONG_CYC
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Fuses and calibration
    input wire logic [3:0] clock_source_select_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic clock_output_fuse,
    input wire logic divide_by_eight_fuse,
    input wire logic [6:0] factory_trim,
    // Clocks in
    input wire logic oscillator_input_pin,
    input wire logic async_timer_sync,
    input wire logic wake_req,
    // Clock enables out and status
    output logic [6:0] trim_value,
    output logic ext_clock_sel,
    output logic core_clock,
    output logic peripheral_io_clock,
    output logic program_memory_clock,
    output logic async_timer_clock,
    output logic irq_block,
    output logic chip_ready,
    output logic wake_done,
    // Port B bit 0
    output logic portb0_out,
    output logic portb0_oe
);

    // -----------------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------------
    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    wire logic wr_en = psel && penable && pwrite;
    // Read data is registered at the setup edge so it stands with pready.
    wire logic rd_en = psel && !penable && !pwrite;
    wire logic sel_trim = hit(paddr, `SCP_OSC_TRIM_OFS);
    wire logic sel_div = hit(paddr, `SCP_CLK_DIV_OFS);
    wire logic sel_stat = hit(paddr, `SCP_STATUS_OFS);
    wire logic bad_addr = !(sel_trim || sel_div || sel_stat);

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------
    logic [6:0] trim_r;
    logic [6:0] trim_nxt;
    logic [3:0] divsel_r;
    logic [3:0] divsel_nxt;
    logic unlock_r;
    logic unlock_nxt;
    logic [2:0] unlock_cnt_r;
    logic [2:0] unlock_cnt_nxt;
    logic strap_done_r;
    logic [31:0] prdata_nxt;
    logic [31:0] rd_trim;
    logic [31:0] rd_div;
    logic [31:0] rd_stat;

    // Unlock needs the bit alone in the low byte; writes with any of bits 6:0 also set are ignored.
    wire logic wr_unlock = wr_en && sel_div && pwdata[`SCP_UNLOCK_BIT] &&
        (pwdata[6:0] == 7'h00);
    wire logic wr_divsel = wr_en && sel_div && !pwdata[`SCP_UNLOCK_BIT];
    wire logic div_load = wr_divsel && unlock_r;

    // Trim resets to 0x00; it is strapped from the calibration byte
    // on the first edge after release, since async reset takes no port.
    assign trim_nxt = !strap_done_r ? factory_trim :
        ((wr_en && sel_trim) ? pwdata[`SCP_TRIM_MSB:0] : trim_r);

    wire logic [3:0] div_strap = divide_by_eight_fuse ?
        `SCP_DIV_RST_BY8 : `SCP_DIV_RST_PLAIN;
    assign divsel_nxt = !strap_done_r ? div_strap :
        (div_load ? pwdata[`SCP_DIVSEL_MSB:0] : divsel_r);

    // Clear on expiry or on any division write, whichever comes first.
    assign unlock_nxt = wr_unlock ? 1'b1 :
        ((wr_divsel || unlock_cnt_r == `SCP_UNLOCK_CYCLES - 3'h1) ?
        1'b0 : unlock_r);
    assign unlock_cnt_nxt = wr_unlock ? 3'h0 :
        (unlock_r ? unlock_cnt_r + 3'h1 : 3'h0);

    assign rd_trim = {24'h000000, 1'b0, trim_r};
    assign rd_div = {24'h000000, unlock_r, 3'h0, divsel_r};
    assign rd_stat = {29'h00000000, wake_done, chip_ready, ext_clock_sel};

    // -----------------------------------------------------------------------
    // Read data select
    // -----------------------------------------------------------------------
    always_comb begin
        prdata_nxt = 32'h00000000;
        if (!rd_en) begin
            prdata_nxt = 32'h00000000;
        end else if (sel_trim) begin
            prdata_nxt = rd_trim;
        end else if (sel_div) begin
            prdata_nxt = rd_div;
        end else if (sel_stat) begin
            prdata_nxt = rd_stat;
        end
    end

    // -----------------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            strap_done_r <= 1'b0;
        end else begin
            strap_done_r <= 1'b1;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trim_r <= 7'h00;
        end else begin
            trim_r <= trim_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            divsel_r <= `SCP_DIV_RST_PLAIN;
        end else begin
            divsel_r <= divsel_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            unlock_r <= 1'b0;
        end else begin
            unlock_r <= unlock_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            unlock_cnt_r <= 3'h0;
        end else begin
            unlock_cnt_r <= unlock_cnt_nxt;
        end
    end

    // Zero-wait APB: answer registered at the setup edge, ready in the access cycle.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else begin
            prdata <= prdata_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && bad_addr;
        end
    end

    // -----------------------------------------------------------------------
    // Reset delay and wake counts
    // -----------------------------------------------------------------------
    scp_state_type state_r;
    scp_state_type state_nxt;
    logic [31:0] dly_cnt_r;
    logic [2:0] wake_cnt_r;
    wire scp_sut_type sut = scp_sut_type'(startup_time_fuse);
    wire logic ext_sel = (clock_source_select_fuse == `SCP_EXT_CLK_SEL);
    wire logic [31:0] dly_target = (sut == SCP_DLY_SHORT) ? DLY_SHORT_CYC :
        (sut == SCP_DLY_LONG) ? DLY_LONG_CYC : 32'h00000000;
    wire logic dly_over = (dly_cnt_r >= dly_target);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            SCP_ST_HOLD: begin
                // Reserved delay setting keeps the chip held.
                if (sut != SCP_DLY_RSVD) begin
                    state_nxt = SCP_ST_WAIT;
                end
            end
            SCP_ST_WAIT: begin
                if (dly_over) begin
                    state_nxt = SCP_ST_RUN;
                end
            end
            default: begin
                state_nxt = SCP_ST_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= SCP_ST_HOLD;
            dly_cnt_r <= 32'h00000000;
            wake_cnt_r <= 3'h0;
        end else begin
            state_r <= state_nxt;
            dly_cnt_r <= (state_r == SCP_ST_WAIT && !dly_over) ?
                dly_cnt_r + 32'h00000001 : dly_cnt_r;
            // Six clocks from a wake request.
            wake_cnt_r <= wake_req ? 3'h0 :
                ((wake_cnt_r != `SCP_WAKE_CK) ? wake_cnt_r + 3'h1 :
                wake_cnt_r);
        end
    end

    // -----------------------------------------------------------------------
    // Glitch-free prescaler
    // -----------------------------------------------------------------------
    // Division is latched only at a falling edge of the divided clock, so a
    // change lands at a period boundary and no short pulse is produced.
    logic [3:0] div_act_r;
    logic [7:0] presc_cnt_r;
    logic clk_div_r;
    wire logic [3:0] div_safe = (divsel_r > `SCP_DIV_MAX_CODE) ?
        `SCP_DIV_MAX_CODE : divsel_r;
    // Each half period lasts two to the power of the code in sys_clk cycles.
    wire logic [7:0] half_mask = (div_act_r == 4'h0) ? 8'h00 :
        8'((9'h001 << div_act_r) - 9'h001);
    wire logic presc_wrap = ((presc_cnt_r & half_mask) == half_mask);
    wire logic bypass = (div_act_r == 4'h0);
    wire logic clk_div_nxt = bypass ? ~clk_div_r :
        (presc_wrap ? ~clk_div_r : clk_div_r);
    wire logic fall = clk_div_r && (bypass || presc_wrap);

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_act_r <= `SCP_DIV_RST_PLAIN;
            presc_cnt_r <= 8'h00;
            clk_div_r <= 1'b0;
        end else begin
            clk_div_r <= clk_div_nxt;
            presc_cnt_r <= fall ? 8'h00 : presc_cnt_r + 8'h01;
            if (fall) begin
                div_act_r <= div_safe;
            end
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------
    wire logic src_clk = ext_sel ? oscillator_input_pin : clk_div_r;
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            trim_value <= 7'h00;
            ext_clock_sel <= 1'b0;
        end else begin
            trim_value <= trim_nxt;
            ext_clock_sel <= ext_sel;
        end
    end

    // The three synchronous clocks share one divider so they never skew.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_clock <= 1'b0;
            peripheral_io_clock <= 1'b0;
            program_memory_clock <= 1'b0;
            async_timer_clock <= 1'b0;
        end else begin
            core_clock <= clk_div_nxt;
            peripheral_io_clock <= clk_div_nxt;
            program_memory_clock <= clk_div_nxt;
            async_timer_clock <= async_timer_sync && clk_div_nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_block <= 1'b0;
            chip_ready <= 1'b0;
            wake_done <= 1'b0;
        end else begin
            irq_block <= unlock_nxt;
            chip_ready <= (state_nxt == SCP_ST_RUN);
            wake_done <= (wake_cnt_r == `SCP_WAKE_CK);
        end
    end

    // The pin keeps its drive through reset, so these flops have no reset.
    always_ff @(posedge sys_clk) begin
        portb0_out <= clock_output_fuse && src_clk;
        portb0_oe <= clock_output_fuse;
    end

endmodule

`default_nettype wire

// *** hw/scp_map.svh ***
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ---------------------------------------------------------------------------
// Register offsets (byte addresses on APB)
// ---------------------------------------------------------------------------
`define SCP_OSC_TRIM_OFS 12'h000
`define SCP_CLK_DIV_OFS 12'h004
`define SCP_STATUS_OFS 12'h008

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define SCP_UNLOCK_BIT 7
`define SCP_TRIM_MSB 6
`define SCP_DIVSEL_MSB 3
`define SCP_DIV_RST_PLAIN 4'h0
`define SCP_DIV_RST_BY8 4'h3
`define SCP_DIV_MAX_CODE 4'h8
`define SCP_EXT_CLK_SEL 4'h0

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define SCP_UNLOCK_CYCLES 3'h4
`define SCP_WAKE_CK 3'h6
`define SCP_CLK_MHZ 50
`define SCP_DLY_SHORT_US 4100
`define SCP_DLY_LONG_US 65000
`define SCP_DLY_SHORT_CYC (`SCP_DLY_SHORT_US * `SCP_CLK_MHZ)
`define SCP_DLY_LONG_CYC (`SCP_DLY_LONG_US * `SCP_CLK_MHZ)

`endif

// *** hw/scp_pkg.sv ***
package scp_pkg;
    typedef enum logic [1:0] {
        SCP_DLY_NONE = 2'b00,
        SCP_DLY_SHORT = 2'b01,
        SCP_DLY_LONG = 2'b10,
        SCP_DLY_RSVD = 2'b11
    } scp_sut_type;

    typedef enum logic [1:0] {
        SCP_ST_HOLD = 2'b00,
        SCP_ST_WAIT = 2'b01,
        SCP_ST_RUN = 2'b10
    } scp_state_type;
endpackage

// *** testbench/scp_clock_ctrl_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Checker for the clock control block
// ------------------------------------------------------------
module scp_clock_ctrl_assertions (
    // Clock, reset and bus
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    // Fuses and straps
    input wire logic [3:0] clock_source_select_fuse,
    input wire logic [1:0] startup_time_fuse,
    input wire logic clock_output_fuse,
    input wire logic [6:0] factory_trim,
    input wire logic async_timer_sync,
    input wire logic wake_req,
    // Outputs watched
    input wire logic [6:0] trim_value,
    input wire logic ext_clock_sel,
    input wire logic core_clock,
    input wire logic peripheral_io_clock,
    input wire logic program_memory_clock,
    input wire logic async_timer_clock,
    input wire logic irq_block,
    input wire logic chip_ready,
    input wire logic wake_done,
    input wire logic portb0_oe
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_div_taken;
        psel && penable && pready && pwrite && paddr == 12'h004;
    endsequence
    sequence s_unlock_wr;
        s_div_taken ##0 pwdata[7:0] == 8'h80;
    endsequence
    a_trim_msb_zero: assert property (
        pready && !pwrite && paddr == 12'h000 |-> !prdata[7])
        else $error("trim bit 7 read as one");
    a_trim_reset_load: assert property (
        $fell(sys_rst) |=> trim_value == factory_trim)
        else $error("trim not loaded after reset");
    a_unlock_blocks: assert property (
        s_unlock_wr |=> irq_block)
        else $error("unlock did not block interrupts");
    a_unlock_expire: assert property (
        $rose(irq_block) |-> ##[1:4] !irq_block)
        else $error("unlock window too long");
    a_div_write_ends: assert property (
        irq_block ##0 s_div_taken ##0 !pwdata[7] |=> !irq_block)
        else $error("unlock kept after write");
    a_ext_select: assert property (
        1 |=> ext_clock_sel == ($past(clock_source_select_fuse) == 4'h0))
        else $error("bad source select");
    a_clk_pin_drive: assert property (
        clock_output_fuse |=> portb0_oe)
        else $error("clock pin not driven");
    a_clocks_agree: assert property (
        peripheral_io_clock == core_clock &&
        program_memory_clock == core_clock)
        else $error("divided clocks differ");
    a_async_gate: assert property (
        !async_timer_sync |=> !async_timer_clock)
        else $error("timer clock not gated");
    a_wake_six: assert property (
        wake_req |=> ##1 !wake_done ##6 wake_done)
        else $error("wake count wrong");
    a_ready_fast: assert property (
        $fell(sys_rst) && startup_time_fuse == 2'b00 |-> ##[1:3] chip_ready)
        else $error("ready late");
endmodule
bind scp_clock_ctrl scp_clock_ctrl_assertions chk_u (.*);
`default_nettype wire

// *** testbench/scp_clock_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module scp_clock_ctrl_test;
    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, last_err;
    logic clock_output_fuse, divide_by_eight_fuse, oscillator_input_pin;
    logic async_timer_sync, wake_req, core_clock, portb0_oe, irq_block;
    logic wake_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] clock_source_select_fuse;
    logic [1:0] startup_time_fuse;
    logic [6:0] factory_trim;
    int err_total, num_checks, cyc;
    // Short delay counts keep the run brief.
    scp_clock_ctrl #(.DLY_SHORT_CYC(20), .DLY_LONG_CYC(50)) dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr),
        .clock_source_select_fuse(clock_source_select_fuse),
        .startup_time_fuse(startup_time_fuse),
        .clock_output_fuse(clock_output_fuse),
        .divide_by_eight_fuse(divide_by_eight_fuse),
        .factory_trim(factory_trim),
        .oscillator_input_pin(oscillator_input_pin),
        .async_timer_sync(async_timer_sync), .wake_req(wake_req),
        .trim_value(), .ext_clock_sel(), .core_clock(core_clock),
        .peripheral_io_clock(), .program_memory_clock(),
        .async_timer_clock(), .irq_block(irq_block), .chip_ready(),
        .wake_done(wake_done), .portb0_out(), .portb0_oe(portb0_oe)
    );
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        rdat = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask
    // Measures one settled period of the divided clock in cycles.
    task automatic per(input int n);
        realtime t0;
        repeat (3) @(posedge core_clock);
        t0 = $realtime;
        @(posedge core_clock);
        chk(32'(int'(($realtime - t0) / 20.0)), 32'(2 ** (n + 1)));
        @(posedge sys_clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_trim();
        rd(12'h000, 32'h5A);
        rd(12'h004, 32'h3);
        bus(1'b1, 12'h000, 32'hFF);
        rd(12'h000, 32'h7F);
        bus(1'b1, 12'h000, 32'h0);
        rd(12'h000, 32'h0);
    endtask
    task automatic t_divide();
        for (int n = 0; n <= 8; n++) begin
            bus(1'b1, 12'h004, 32'h80);
            bus(1'b1, 12'h004, 32'(n));
            rd(12'h004, 32'(n));
            per(n);
        end
    endtask
    task automatic t_lock();
        bus(1'b1, 12'h004, 32'h5);
        rd(12'h004, 32'h8);
        bus(1'b1, 12'h004, 32'h81);
        chk(32'(irq_block), 32'h0);
        bus(1'b1, 12'h004, 32'h80);
        chk(32'(irq_block), 32'h1);
        repeat (6) @(posedge sys_clk);
        bus(1'b1, 12'h004, 32'h2);
        rd(12'h004, 32'h8);
    endtask
    task automatic t_status();
        bus(1'b0, 12'h008, 32'h0);
        chk(rdat & 32'h3, 32'h3);
        chk(32'(portb0_oe), 32'h1);
        rd(12'h00C, 32'h0);
        chk(32'(last_err), 32'h1);
        wake_req <= 1'b1;
        @(posedge sys_clk);
        wake_req <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk(32'(wake_done), 32'h0);
        repeat (6) @(posedge sys_clk);
        chk(32'(wake_done), 32'h1);
    endtask
    task automatic t_reset_plain();
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk(32'(portb0_oe), 32'h1);
        divide_by_eight_fuse <= 1'b0;
        startup_time_fuse <= 2'b00;
        clock_source_select_fuse <= 4'h2;
        clock_output_fuse <= 1'b0;
        async_timer_sync <= 1'b0;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rd(12'h004, 32'h0);
        bus(1'b0, 12'h008, 32'h0);
        chk(rdat & 32'h1, 32'h0);
        chk(32'(portb0_oe), 32'h0);
    endtask
    // ------------------------------------------------------------
    // Clock, timeout and main sequence
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        oscillator_input_pin <= ~oscillator_input_pin;
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            give_verdict();
        end
    end
    initial begin
        {psel, penable, pwrite, wake_req, last_err} = 5'h0;
        {paddr, pwdata} = 44'h0;
        sys_rst = 1'b1;
        oscillator_input_pin = 1'b0;
        clock_source_select_fuse = 4'h0;
        startup_time_fuse = 2'b01;
        {clock_output_fuse, divide_by_eight_fuse} = 2'b11;
        async_timer_sync = 1'b1;
        factory_trim = 7'h5A;
        repeat (10) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_reset_trim();
        t_divide();
        t_lock();
        t_status();
        t_reset_plain();
        give_verdict();
    end
endmodule
`default_nettype wire
